// ---- pkg/pcs_defs.svh ----
/*
  constants for the clock synthesis control block: ranges, lock gating,
  feedback mode codes.
  assumes inclusion by bare name from the device and user design files.
*/
`ifndef PCS_DEFS_SVH
`define PCS_DEFS_SVH
// ==================================================
// divider ranges
`define PCS_MULT_MIN 6'h01
`define PCS_MULT_MAX 6'h20
`define PCS_PRE_MIN 3'h1
`define PCS_PRE_MAX 3'h4
// ==================================================
// software port offsets and register reset values
`define PCS_A_CTRL 4'h0
`define PCS_A_LOOP 4'h1
`define PCS_A_OUT0 4'h2
`define PCS_A_OUT1 4'h3
`define PCS_A_OUT2 4'h4
`define PCS_A_STAT 4'h5
`define PCS_CTRL_RST 8'h04
`define PCS_DIV_RST 6'h01
// ==================================================
// phase steps per oscillator period
`define PCS_PHASE_STEPS 4'h8
// ==================================================
// lock gating
`define PCS_LOCK_GATE_RST 16'h0100
`define PCS_LOCK_STABLE 4'h4
// ==================================================
// feedback modes
`define PCS_FB_NORMAL 2'h0
`define PCS_FB_ZDB 2'h1
`define PCS_FB_NOCOMP 2'h3
`endif

// ---- pkg/pcs_pkg.sv ----
/*
  types shared by both ends of the clock synthesis control link.
  numeric codes are written as literals here, matching pcs_defs.svh.
*/
package pcs_pkg;
  typedef logic [5:0] pcs_cnt_t;
  typedef logic [2:0] pcs_pre_t;
  typedef logic [2:0] pcs_phase_t;
  typedef enum logic [1:0] {
    pcs_fb_normal = 2'h0,
    pcs_fb_zdb = 2'h1,
    pcs_fb_nocomp = 2'h3
  } pcs_fb_e;
  typedef struct packed {
    pcs_cnt_t div;
    pcs_cnt_t high;
    pcs_phase_t phase;
  } pcs_out_s;
  typedef enum logic [1:0] {
    pcs_st_off = 2'h0,
    pcs_st_settle = 2'h1,
    pcs_st_locked = 2'h3
  } pcs_st_e;
endpackage

// ---- pkg/pcs_if.sv ----
/*
  link between the clock synthesis device and its user logic.
  assumes both ends share ref_clk and reset.
*/
`timescale 1ns/1ps
interface pcs_if;
  import pcs_pkg::*;
  // control from user logic
  logic loop_enable;
  logic loop_areset;
  logic pfd_enable;
  logic reference_select;
  logic [15:0] lock_gate_count;
  logic lock_gated_sel;
  logic out_pin_enable;
  pcs_fb_e fb_mode;
  pcs_pre_t pre_div;
  pcs_cnt_t mult;
  pcs_out_s post_divider_0;
  pcs_out_s post_divider_1;
  pcs_out_s post_divider_2;
  // results from device
  logic [2:0] clk_out;
  logic ext_clk_out;
  logic ext_clk_out_oe;
  logic locked;
  logic locked_raw;
  logic ref_pin_pair_busy;
  modport device (
    input loop_enable, loop_areset, pfd_enable, reference_select, lock_gate_count,
    input lock_gated_sel, out_pin_enable, fb_mode, pre_div, mult,
    input post_divider_0, post_divider_1, post_divider_2,
    output clk_out, ext_clk_out, ext_clk_out_oe, locked, locked_raw, ref_pin_pair_busy
  );
  modport user (
    output loop_enable, loop_areset, pfd_enable, reference_select, lock_gate_count,
    output lock_gated_sel, out_pin_enable, fb_mode, pre_div, mult,
    output post_divider_0, post_divider_1, post_divider_2,
    input clk_out, ext_clk_out, ext_clk_out_oe, locked, locked_raw, ref_pin_pair_busy
  );
endinterface

// ---- hw/pcs_device.sv ----
/*
  digital model of the clock synthesis loop: reference select, pre-divider,
  multiplier, three post dividers with phase and duty, gated lock.
  assumes two reference clock inputs sampled on ref_clk and user logic
  driving the control side of pcs_if.
*/
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "pcs_defs.svh"
module pcs_device (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // reference pins
  input wire logic ref_in_0,
  input wire logic ref_in_1,
  input wire logic ref_differential,
  // link
  pcs_if.device link
);
  import pcs_pkg::*;

  // ==================================================
  // input synchronisers
  logic [1:0] ref0_s_r, ref1_s_r, sel_s_r, en_s_r, pfd_s_r;
  logic rst_meta_r, rst_sync_r;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= 1'b1;
    end else begin
      rst_meta_r <= link.loop_areset;
      rst_sync_r <= rst_meta_r;
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ref0_s_r <= 2'h0;
      ref1_s_r <= 2'h0;
      sel_s_r <= 2'h0;
      en_s_r <= 2'h0;
      pfd_s_r <= 2'h0;
    end else begin
      ref0_s_r <= {ref0_s_r[0], ref_in_0};
      ref1_s_r <= {ref1_s_r[0], ref_in_1};
      sel_s_r <= {sel_s_r[0], link.reference_select};
      en_s_r <= {en_s_r[0], link.loop_enable};
      pfd_s_r <= {pfd_s_r[0], link.pfd_enable};
    end
  end

  // ==================================================
  // reference multiplexer and edge detect
  logic ref_mux, ref_prev_r, ref_edge, sel_prev_r, run;
  assign ref_mux = sel_s_r[1] ? ref1_s_r[1] : ref0_s_r[1];
  assign ref_edge = ref_mux & ~ref_prev_r;
  assign run = en_s_r[1] & ~rst_sync_r;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ref_prev_r <= 1'b0;
      sel_prev_r <= 1'b0;
    end else begin
      ref_prev_r <= ref_mux;
      sel_prev_r <= sel_s_r[1];
    end
  end

  // ==================================================
  // settings check and oscillator tick
  function automatic logic cnt_ok(input pcs_cnt_t v);
    cnt_ok = (v >= `PCS_MULT_MIN) && (v <= `PCS_MULT_MAX);
  endfunction
  logic cfg_ok;
  assign cfg_ok = cnt_ok(link.mult) && cnt_ok(link.post_divider_0.div) &&
                  cnt_ok(link.post_divider_1.div) && cnt_ok(link.post_divider_2.div) &&
                  (link.pre_div >= `PCS_PRE_MIN) && (link.pre_div <= `PCS_PRE_MAX);
  // the pre-divider counts reference edges, the multiplier is modelled as
  // m oscillator ticks per divided edge, each tick split into eight phases
  pcs_pre_t pre_cnt_r;
  logic pfd_pulse;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pre_cnt_r <= 3'h0;
    end else if (!run || !cfg_ok) begin
      pre_cnt_r <= 3'h0;
    end else if (ref_edge) begin
      pre_cnt_r <= (pre_cnt_r + 3'h1 >= link.pre_div) ? 3'h0 : pre_cnt_r + 3'h1;
    end
  end
  // detector output only passes while its gate is open
  assign pfd_pulse = run && cfg_ok && ref_edge && (pre_cnt_r == 3'h0) && pfd_s_r[1];

  // ==================================================
  // oscillator ticks: m per detector pulse
  pcs_cnt_t m_left_r;
  logic [2:0] vco_phase_r;
  logic vco_tick;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      m_left_r <= 6'h00;
      vco_phase_r <= 3'h0;
    end else if (!run) begin
      m_left_r <= 6'h00;
      vco_phase_r <= 3'h0;
    end else if (pfd_pulse) begin
      m_left_r <= link.mult;
      vco_phase_r <= 3'h0;
    end else if (m_left_r != 6'h00) begin
      vco_phase_r <= vco_phase_r + 3'h1;
      if (vco_phase_r == 3'(`PCS_PHASE_STEPS - 4'h1)) begin
        m_left_r <= m_left_r - 6'h01;
      end
    end
  end
  assign vco_tick = (m_left_r != 6'h00) && (vco_phase_r == 3'h7);

  // ==================================================
  // post dividers with phase and duty
  pcs_out_s pd [3];
  assign pd[0] = link.post_divider_0;
  assign pd[1] = link.post_divider_1;
  assign pd[2] = link.post_divider_2;
  pcs_cnt_t c_cnt_r [3];
  logic [2:0] clk_r;
  for (genvar i = 0; i < 3; i++) begin : g_post
    always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
        c_cnt_r[i] <= 6'h00;
        clk_r[i] <= 1'b0;
      end else if (!run) begin
        c_cnt_r[i] <= 6'h00;
        clk_r[i] <= 1'b0;
      end else begin
        // phase offset picks the sub-tick at which the counter advances
        if ((m_left_r != 6'h00) && (vco_phase_r == pd[i].phase)) begin
          c_cnt_r[i] <= (c_cnt_r[i] + 6'h01 >= pd[i].div) ? 6'h00 : c_cnt_r[i] + 6'h01;
        end
        clk_r[i] <= (c_cnt_r[i] < pd[i].high);
      end
    end
  end

  // ==================================================
  // lock detection and gating
  pcs_st_e st_r;
  logic [15:0] gate_cnt_r;
  logic [3:0] stable_r;
  logic locked_raw_r, locked_r, ext_r, ext_oe_r;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      stable_r <= 4'h0;
    end else if (!run || !cfg_ok || (sel_s_r[1] != sel_prev_r)) begin
      stable_r <= 4'h0;
    end else if (pfd_pulse && stable_r != `PCS_LOCK_STABLE) begin
      stable_r <= stable_r + 4'h1;
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_r <= pcs_st_off;
      gate_cnt_r <= `PCS_LOCK_GATE_RST;
    end else if (!run) begin
      st_r <= pcs_st_off;
      gate_cnt_r <= link.lock_gate_count;
    end else begin
      case (st_r)
        pcs_st_off: begin
          st_r <= pcs_st_settle;
          gate_cnt_r <= link.lock_gate_count;
        end
        pcs_st_settle: begin
          if (ref_mux != ref_prev_r && gate_cnt_r != 16'h0000) begin
            gate_cnt_r <= gate_cnt_r - 16'h0001;
          end
          if (gate_cnt_r == 16'h0000) begin
            st_r <= pcs_st_locked;
          end
        end
        pcs_st_locked: st_r <= pcs_st_locked;
        default: st_r <= pcs_st_off;
      endcase
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      locked_raw_r <= 1'b0;
      locked_r <= 1'b0;
    end else begin
      locked_raw_r <= run && (stable_r == `PCS_LOCK_STABLE);
      locked_r <= run && (stable_r == `PCS_LOCK_STABLE) &&
                  (link.lock_gated_sel ? (st_r == pcs_st_locked) : 1'b1);
    end
  end
  // feedback mode: compensation is analog; digitally every mode starts the
  // post dividers on the detector pulse so the pin and network share edges
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ext_r <= 1'b0;
      ext_oe_r <= 1'b0;
    end else begin
      ext_r <= (c_cnt_r[2] < pd[2].high) && run;
      ext_oe_r <= link.out_pin_enable;
    end
  end
  // pin level: two flops before it is shown
  logic [1:0] pair_s_r;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pair_s_r <= 2'h0;
    end else begin
      pair_s_r <= {pair_s_r[0], ref_differential};
    end
  end
  assign link.clk_out = clk_r;
  assign link.ext_clk_out = ext_r;
  assign link.ext_clk_out_oe = ext_oe_r;
  assign link.locked = locked_r;
  assign link.locked_raw = locked_raw_r;
  assign link.ref_pin_pair_busy = pair_s_r[1];
endmodule

// ---- hw/pcs_user.sv ----
/*
  user logic end: holds loop settings from a software port and drives the
  control side of pcs_if; reports lock state back.
  assumes the device end on the same ref_clk.
*/
`timescale 1ns/1ps
`include "pcs_defs.svh"
module pcs_user (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // software port
  input wire logic [3:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  // link
  pcs_if.user link
);
  import pcs_pkg::*;

  // ==================================================
  // register offsets
  localparam logic [3:0] A_CTRL = `PCS_A_CTRL;
  localparam logic [3:0] A_LOOP = `PCS_A_LOOP;
  localparam logic [3:0] A_OUT0 = `PCS_A_OUT0;
  localparam logic [3:0] A_OUT1 = `PCS_A_OUT1;
  localparam logic [3:0] A_OUT2 = `PCS_A_OUT2;
  localparam logic [3:0] A_STAT = `PCS_A_STAT;

  logic [7:0] ctrl_r;
  logic [26:0] loop_r;
  pcs_out_s out_r [3];
  logic [31:0] rdata_r;
  // lock sampling: device outputs are registered on this clock
  logic [2:0] stat_r;

  // ==================================================
  // register writes
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_r <= `PCS_CTRL_RST;
      loop_r <= {`PCS_LOCK_GATE_RST, `PCS_FB_NORMAL, `PCS_PRE_MIN, `PCS_MULT_MIN};
      for (int i = 0; i < 3; i++) begin
        out_r[i] <= '{div: `PCS_DIV_RST, high: `PCS_DIV_RST, phase: 3'h0};
      end
    end else if (sw_wr) begin
      case (sw_addr)
        A_CTRL: ctrl_r <= sw_wdata[7:0];
        A_LOOP: loop_r <= sw_wdata[26:0];
        A_OUT0: out_r[0] <= sw_wdata[14:0];
        A_OUT1: out_r[1] <= sw_wdata[14:0];
        A_OUT2: out_r[2] <= sw_wdata[14:0];
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      stat_r <= 3'h0;
    end else begin
      stat_r <= {link.ref_pin_pair_busy, link.locked_raw, link.locked};
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rdata_r <= 32'h0;
    end else if (sw_rd) begin
      case (sw_addr)
        A_CTRL: rdata_r <= {24'h0, ctrl_r};
        A_LOOP: rdata_r <= {5'h0, loop_r};
        A_OUT0: rdata_r <= {17'h0, out_r[0]};
        A_OUT1: rdata_r <= {17'h0, out_r[1]};
        A_OUT2: rdata_r <= {17'h0, out_r[2]};
        A_STAT: rdata_r <= {29'h0, stat_r};
        default: rdata_r <= 32'h0;
      endcase
    end else begin
      rdata_r <= 32'h0;
    end
  end
  assign sw_rdata = rdata_r;

  // ==================================================
  // drive link
  assign link.loop_enable = ctrl_r[0];
  assign link.loop_areset = ctrl_r[1];
  assign link.pfd_enable = ctrl_r[2];
  assign link.reference_select = ctrl_r[3];
  assign link.lock_gated_sel = ctrl_r[4];
  assign link.out_pin_enable = ctrl_r[5];
  assign link.mult = loop_r[5:0];
  assign link.pre_div = loop_r[8:6];
  assign link.fb_mode = pcs_fb_e'(loop_r[10:9]);
  assign link.lock_gate_count = loop_r[26:11];
  assign link.post_divider_0 = out_r[0];
  assign link.post_divider_1 = out_r[1];
  assign link.post_divider_2 = out_r[2];
endmodule

// ---- bench/pcs_link_asserts.sv ----
/* checker for the pcs link between the device and user ends.
   assumes one ref_clk domain, instantiated beside pcs_if. */
`timescale 1ns/1ps
module pcs_link_asserts (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // controls
  input wire logic loop_enable,
  input wire logic loop_areset,
  input wire logic pfd_enable,
  input wire logic reference_select,
  input wire logic lock_gated_sel,
  input wire logic out_pin_enable,
  // results
  input wire logic [2:0] clk_out,
  input wire logic ext_clk_out,
  input wire logic ext_clk_out_oe,
  input wire logic locked,
  input wire logic locked_raw
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  // ==========
  // idle counter, saturating to stay small
  logic [3:0] off_cnt_r;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) off_cnt_r <= 4'h0;
    else if (loop_enable) off_cnt_r <= 4'h0;
    else if (off_cnt_r != 4'hf) off_cnt_r <= off_cnt_r + 4'h1;
  end
  // ==========
  // link checks
  a_lock_has_raw: assert property (locked |-> locked_raw || $past(locked_raw))
    else $error("locked without raw lock");
  a_disable_drops: assert property (
    $fell(loop_enable) |-> ##[1:4] !locked && !locked_raw)
    else $error("lock kept after disable");
  a_areset_drops: assert property (loop_areset |-> ##[1:4] !locked_raw)
    else $error("lock kept in loop reset");
  a_raw_needs_en: assert property ($rose(locked_raw) |-> $past(loop_enable, 3))
    else $error("lock while disabled");
  a_raw_needs_pfd: assert property ($rose(locked_raw) |-> $past(pfd_enable, 3))
    else $error("lock with detector gated");
  a_ungated_follows: assert property (
    (!lock_gated_sel && locked_raw) [*3] |-> locked)
    else $error("ungated lock not passed");
  a_pin_oe_follows: assert property (
    $stable(out_pin_enable) [*3] |-> ext_clk_out_oe == out_pin_enable)
    else $error("pin enable not followed");
  a_pin_tracks_c2: assert property (ext_clk_out == clk_out[2])
    else $error("pin clock differs from third output");
  a_idle_quiet: assert property (off_cnt_r > 4'h8 |-> $stable(clk_out) && !locked)
    else $error("outputs move while disabled");
  a_select_restart: assert property (
    $changed(reference_select) |-> ##[1:5] !locked_raw)
    else $error("lock kept across switchover");
  c_gated_lock: cover property ($rose(locked) && lock_gated_sel);
  c_lock_lost: cover property ($fell(locked_raw));
  c_pin_on: cover property ($rose(ext_clk_out_oe));
endmodule

// ---- bench/pll_clock_synth_control_tb_top.sv ----
/* bench top: both ends joined by pcs_if, software port checked against a
   register and rate model. assumes package, interface and checker. */
`timescale 1ns/1ps
module pll_clock_synth_control_tb_top;
  import pcs_pkg::*;
  // ==========
  // stimulus and model state
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic ref_in_0 = 1'b0;
  logic ref_in_1 = 1'b0;
  logic ref_diff = 1'b0;
  logic [3:0] sw_addr = 4'h0;
  logic [31:0] sw_wdata = 32'h0;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [31:0] sw_rdata;
  logic [31:0] seed = 32'h00007ce7;
  logic [31:0] regs [5] = '{32'h04, 32'h00080041, 32'h208, 32'h208, 32'h208};
  logic [31:0] msk [5] = '{32'hff, 32'h07ffffff, 32'h7fff, 32'h7fff, 32'h7fff};
  int n_fail = 0;
  int checks_done = 0;
  int tick = 0;
  always #2 ref_clk = ~ref_clk;
  // two unrelated reference rates, gaps wide enough for m up to 16
  always @(posedge ref_clk) begin
    tick <= tick + 1;
    if (tick % 64 == 63) ref_in_0 <= ~ref_in_0;
    if (tick % 96 == 95) ref_in_1 <= ~ref_in_1;
  end
  pcs_if link ();
  pcs_device i_pcs_device (.ref_clk(ref_clk), .reset(reset), .ref_in_0(ref_in_0),
    .ref_in_1(ref_in_1), .ref_differential(ref_diff), .link(link));
  pcs_user i_pcs_user (.ref_clk(ref_clk), .reset(reset), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .link(link));
  pcs_link_asserts i_pcs_link_asserts (.ref_clk(ref_clk), .reset(reset),
    .loop_enable(link.loop_enable), .loop_areset(link.loop_areset),
    .pfd_enable(link.pfd_enable), .reference_select(link.reference_select),
    .lock_gated_sel(link.lock_gated_sel), .out_pin_enable(link.out_pin_enable),
    .clk_out(link.clk_out), .ext_clk_out(link.ext_clk_out),
    .ext_clk_out_oe(link.ext_clk_out_oe),
    .locked(link.locked), .locked_raw(link.locked_raw));
  // ==========
  // helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic miss(input logic [31:0] g, input logic [31:0] e);
    n_fail++;
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) miss(g, e);
  endtask
  // edge counts drift by one with synchroniser phase
  task automatic cmp_rate(input int g, input int e);
    checks_done++;
    if (g < e - 1 || g > e + 1) miss(g, e);
  endtask
  // each access starts on a rising edge, whatever time the caller is at
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge ref_clk);
    sw_wr <= 1'b0;
  endtask
  task automatic chk_rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge ref_clk);
    sw_rd <= 1'b0;
    #1 cmp(sw_rdata, e);
  endtask
  task automatic mwr(input logic [3:0] a, input logic [31:0] d);
    wr(a, d);
    if (a < 4'h5) regs[a] = d & msk[a];
  endtask
  task automatic wait_lock(input logic gated, input int lim, output int w);
    w = 0;
    while ((gated ? link.locked : link.locked_raw) !== 1'b1) begin
      if (w == lim) begin
        miss(32'h0, 32'h1);
        report_and_stop();
      end
      @(posedge ref_clk);
      #1 w++;
    end
  endtask
  task automatic rate_case(input int m, input int n, input int d0, input int d1, input int d2);
    int dv [3];
    int rises [3];
    int w;
    logic [2:0] prev;
    dv = '{d0, d1, d2};
    rises = '{0, 0, 0};
    mwr(4'h0, 32'h04);
    mwr(4'h1, m | (n << 6) | (4 << 11));
    for (int i = 0; i < 3; i++) mwr(4'h2 + i[3:0], (dv[i] << 9) | ((dv[i] / 2) << 3));
    mwr(4'h0, 32'h05);
    wait_lock(1'b0, 4000, w);
    prev = link.clk_out;
    repeat (2048) begin
      @(posedge ref_clk);
      #1;
      for (int i = 0; i < 3; i++) if (link.clk_out[i] && !prev[i]) rises[i]++;
      prev = link.clk_out;
    end
    cmp(link.locked, 1'b1);
    for (int i = 0; i < 3; i++) cmp_rate(rises[i], 16 * m / (n * dv[i]));
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ==========
  // main sequence
  initial begin
    int w;
    int w2;
    logic [31:0] d;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    for (int a = 0; a < 5; a++) chk_rd(a[3:0], regs[a]);
    chk_rd(4'hf, 32'h0);
    mwr(4'h5, 32'hffffffff);
    chk_rd(4'h5, 32'h0);
    for (int k = 0; k < 6; k++) begin
      d = xs();
      d = {17'h0, 6'(d[4:0]) + 6'h1, 1'b0, d[9:5], d[12:10]};
      mwr(4'h2 + 4'(k % 3), d);
      chk_rd(4'h2 + 4'(k % 3), regs[2 + k % 3]);
    end
    for (int f = 0; f < 4; f++) begin
      if (f != 2) begin
        mwr(4'h1, 32'h00080041 | (f << 9));
        chk_rd(4'h1, regs[1]);
      end
    end
    rate_case(4, 1, 2, 4, 8);
    rate_case(3, 2, 3, 2, 3);
    rate_case(2, 1, 2, 2, 4);
    mwr(4'h0, 32'h25);
    repeat (4) @(posedge ref_clk);
    #1 cmp(link.ext_clk_out_oe, 1'b1);
    mwr(4'h0, 32'h2d);
    repeat (8) @(posedge ref_clk);
    #1 cmp(link.locked_raw, 1'b0);
    wait_lock(1'b0, 4000, w);
    chk_rd(4'h5, 32'h3);
    mwr(4'h0, 32'h2f);
    repeat (4) @(posedge ref_clk);
    chk_rd(4'h5, 32'h0);
    mwr(4'h0, 32'h04);
    repeat (6) @(posedge ref_clk);
    chk_rd(4'h5, 32'h0);
    mwr(4'h1, 32'h41 | (24 << 11));
    mwr(4'h0, 32'h15);
    wait_lock(1'b0, 4000, w);
    cmp(link.locked, 1'b0);
    wait_lock(1'b1, 6000, w2);
    // 24 transitions 64 cycles apart: at least 23 full gaps, at most 24 plus pipeline
    cmp(w + w2 >= 23 * 64 && w + w2 <= 24 * 64 + 16, 1'b1);
    @(posedge ref_clk);
    ref_diff <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 cmp(link.ref_pin_pair_busy, 1'b1);
    report_and_stop();
  end
endmodule
